// file: hdl/isp_defines.svh
// timing and layout constants for the split-strobe host port
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH
`define ISP_DATA_W 16
`define ISP_ADDR_W 16
`define ISP_MEM_DEPTH 256
`define ISP_MEM_AW 8
`define ISP_CLK_PERIOD_NS 40
`define ISP_WAIT_LEN_TS 2
`define ISP_EXTRA_TS 3
`define ISP_CYCLE_TS (`ISP_WAIT_LEN_TS + `ISP_EXTRA_TS)
`define ISP_CNT_W 4
`define ISP_ADDR_RST 16'h0000
`define ISP_DATA_RST 16'h0000
`endif

// file: hdl/isp_pkg.sv
// opcode type shared by both ends of the split-strobe host port, plus each end's own state type
package isp_pkg;
  typedef enum logic [1:0] {
    ISP_OP_NONE,
    ISP_OP_CMD,
    ISP_OP_WR,
    ISP_OP_RD
  } isp_op_t;
  typedef enum {
    ISP_D_IDLE,
    ISP_D_STALL,
    ISP_D_HOLD
  } isp_dev_state_t;
  typedef enum {
    ISP_H_IDLE,
    ISP_H_STROBE,
    ISP_H_RELEASE
  } isp_host_state_t;
endpackage

// file: hdl/isp_bus_if.sv
// pin bundle between host and device of the split-strobe host port
interface isp_bus_if;
  logic chip_select_n;
  logic cmd_data_select;
  logic read_strobe_n;
  logic write_strobe_upper_n;
  logic write_strobe_lower_n;
  logic [15:0] host_data;
  logic host_data_oe;
  logic [15:0] dev_data;
  logic dev_data_oe;
  logic wait_out_n;
  logic wait_oe;
  modport host (
    output chip_select_n, cmd_data_select, read_strobe_n,
    output write_strobe_upper_n, write_strobe_lower_n, host_data, host_data_oe,
    input dev_data, dev_data_oe, wait_out_n, wait_oe
  );
  modport device (
    input chip_select_n, cmd_data_select, read_strobe_n,
    input write_strobe_upper_n, write_strobe_lower_n, host_data, host_data_oe,
    output dev_data, dev_data_oe, wait_out_n, wait_oe
  );
endinterface

// file: hdl/isp_word_mem.sv
// word memory with byte-lane writes behind the device end
`include "isp_defines.svh"
module isp_word_mem
  import isp_pkg::*;
(
  input wire logic clock_i,
  input wire logic clk_en_i,
  input wire logic wr_en_i,
  input wire logic [1:0] lane_en_i,
  input wire logic [`ISP_MEM_AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem_r [`ISP_MEM_DEPTH];
  logic [15:0] wword;

  // merge the enabled lanes into the stored word, one writer for the array
  generate
    for (genvar g = 0; g < 2; g++) begin : g_lane
      assign wword[g*8 +: 8] = lane_en_i[g] ? wdata_i[g*8 +: 8] : mem_r[addr_i][g*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (clk_en_i && wr_en_i) begin
      mem_r[addr_i] <= wword;
    end
  end

  always_comb begin
    rdata_o = mem_r[addr_i];
  end
endmodule

// file: hdl/isp_device.sv
// device end of the indirect split-strobe host port
`include "isp_defines.svh"
module isp_device
  import isp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic wait_mode_i,
  isp_bus_if.device bus,
  output logic [15:0] reg_addr_o,
  output logic [15:0] last_wdata_o,
  output logic busy_o
);
  isp_dev_state_t st_r, st_nxt;
  logic [`ISP_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] wlast_r, wlast_nxt;
  logic drive_r, drive_nxt;
  logic wait_r, wait_nxt;
  logic busy_r, busy_nxt;
  logic mem_we;
  logic commit;
  logic [`ISP_MEM_AW-1:0] mem_idx;
  logic [1:0] lanes;
  logic [15:0] mem_q;
  logic wr_any, rd_act, sel;
  isp_op_t op;
  isp_op_t op_r, op_nxt;

  assign sel = !bus.chip_select_n;
  assign wr_any = !(bus.write_strobe_upper_n && bus.write_strobe_lower_n);
  // a read needs both write strobes high
  assign rd_act = !bus.read_strobe_n && !wr_any;
  // active-low strobes map to per-lane enables
  assign lanes = {!bus.write_strobe_upper_n, !bus.write_strobe_lower_n};

  // live decode of the pins; any other combination is ignored
  always_comb begin
    op = ISP_OP_NONE;
    if (sel && bus.read_strobe_n && !bus.cmd_data_select && lanes == 2'b11) begin
      op = ISP_OP_CMD;
    end else if (sel && bus.read_strobe_n && bus.cmd_data_select && wr_any) begin
      op = ISP_OP_WR;
    end else if (sel && bus.cmd_data_select && rd_act) begin
      op = ISP_OP_RD;
    end
  end

  // no byte address bit: the word index starts at address bit 1
  assign mem_idx = addr_r[`ISP_MEM_AW:1];

  isp_word_mem u_mem (
    .clock_i(clock_i),
    .clk_en_i(clk_en_i),
    .wr_en_i(mem_we),
    .lane_en_i(lanes),
    .addr_i(mem_idx),
    .wdata_i(bus.host_data),
    .rdata_o(mem_q)
  );

  // cycle control: stall length, wait pin, read drive and busy
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    drive_nxt = 1'b0;
    wait_nxt = 1'b0;
    busy_nxt = 1'b0;
    commit = 1'b0;
    case (st_r)
      ISP_D_IDLE: begin
        if (op != ISP_OP_NONE) begin
          // stall count in system clock periods; the wait pin is held one period longer
          cnt_nxt = `ISP_CNT_W'(`ISP_WAIT_LEN_TS);
          op_nxt = op;
          st_nxt = ISP_D_STALL;
          wait_nxt = wait_mode_i;
          busy_nxt = 1'b1;
          drive_nxt = (op == ISP_OP_RD);
        end
      end

      ISP_D_STALL: begin
        busy_nxt = 1'b1;
        drive_nxt = (op == ISP_OP_RD);
        if (op != op_r) begin
          // pins changed before the stall ended: drop the cycle, free the wait pin
          st_nxt = ISP_D_IDLE;
          busy_nxt = 1'b0;
          drive_nxt = 1'b0;
        end else if (cnt_r != '0) begin
          cnt_nxt = cnt_r - `ISP_CNT_W'(1);
          wait_nxt = wait_mode_i;
        end else begin
          // commit on the last stall period, data latched as the wait pin is released
          commit = 1'b1;
          st_nxt = ISP_D_HOLD;
        end
      end

      ISP_D_HOLD: begin
        busy_nxt = 1'b1;
        drive_nxt = rd_act && sel;
        // wait released; hold until the strobe rises
        if (!sel || (bus.read_strobe_n && !wr_any)) begin
          st_nxt = ISP_D_IDLE;
          busy_nxt = 1'b0;
          drive_nxt = 1'b0;
        end
      end

      default: begin
        st_nxt = ISP_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ISP_D_IDLE;
      cnt_r <= '0;
      op_r <= ISP_OP_NONE;
      drive_r <= 1'b0;
      wait_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      drive_r <= drive_nxt;
      wait_r <= wait_nxt;
      busy_r <= busy_nxt;
    end
  end

  // register address, kept until the next command write
  always_comb begin
    addr_nxt = addr_r;
    if (commit && op_r == ISP_OP_CMD) begin
      addr_nxt = {bus.host_data[15:1], 1'b0};
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_r <= `ISP_ADDR_RST;
    end else if (clk_en_i) begin
      addr_r <= addr_nxt;
    end
  end

  // data path: memory write strobe, read latch and last written word
  always_comb begin
    rdata_nxt = rdata_r;
    wlast_nxt = wlast_r;
    mem_we = 1'b0;
    if (commit) begin
      case (op_r)
        ISP_OP_WR: begin
          mem_we = 1'b1;
          wlast_nxt = bus.host_data;
        end
        ISP_OP_RD: begin
          rdata_nxt = mem_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= `ISP_DATA_RST;
      wlast_r <= `ISP_DATA_RST;
    end else if (clk_en_i) begin
      rdata_r <= rdata_nxt;
      wlast_r <= wlast_nxt;
    end
  end

  assign bus.dev_data = rdata_r;
  assign bus.dev_data_oe = drive_r;
  // open drain: only ever pulled low, the pull-up gives the high level
  assign bus.wait_out_n = 1'b0;
  assign bus.wait_oe = wait_r;

  assign reg_addr_o = addr_r;
  assign last_wdata_o = wlast_r;
  assign busy_o = busy_r;
endmodule

// file: hdl/isp_host.sv
// host end of the indirect split-strobe host port
`include "isp_defines.svh"
module isp_host
  import isp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic wait_mode_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_op_i,
  input wire logic [1:0] req_lanes_i,
  input wire logic [15:0] req_data_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  isp_bus_if.host bus
);
  isp_host_state_t st_r, st_nxt;
  logic [`ISP_CNT_W-1:0] cnt_r, cnt_nxt;
  logic cs_r, cs_nxt, sel_r, sel_nxt, rd_r, rd_nxt;
  logic [1:0] we_r, we_nxt;
  logic [15:0] d_r, d_nxt, rsp_r, rsp_nxt;
  logic oe_r, oe_nxt, rv_r, rv_nxt, rdy_r, rdy_nxt;
  logic stalled;

  // wait pin low only while the device drives it
  assign stalled = wait_mode_i && bus.wait_oe && !bus.wait_out_n;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cs_nxt = cs_r;
    sel_nxt = sel_r;
    rd_nxt = rd_r;
    we_nxt = we_r;
    d_nxt = d_r;
    oe_nxt = oe_r;
    rsp_nxt = rsp_r;
    rv_nxt = 1'b0;
    rdy_nxt = rdy_r;
    case (st_r)
      ISP_H_IDLE: begin
        if (req_valid_i && rdy_r) begin
          rdy_nxt = 1'b0;
          cs_nxt = 1'b1;
          sel_nxt = (isp_op_t'(req_op_i) != ISP_OP_CMD);
          rd_nxt = (isp_op_t'(req_op_i) == ISP_OP_RD);
          we_nxt = (isp_op_t'(req_op_i) == ISP_OP_CMD) ? 2'b11 :
                   (isp_op_t'(req_op_i) == ISP_OP_WR) ? req_lanes_i : 2'b00;
          d_nxt = req_data_i;
          oe_nxt = (isp_op_t'(req_op_i) != ISP_OP_RD);
          cnt_nxt = `ISP_CNT_W'(`ISP_CYCLE_TS);
          st_nxt = ISP_H_STROBE;
        end
      end
      ISP_H_STROBE: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - `ISP_CNT_W'(1);
        end else if (!stalled) begin
          if (rd_r) begin
            rsp_nxt = bus.dev_data;
            rv_nxt = 1'b1;
          end
          rd_nxt = 1'b0;
          we_nxt = 2'b00;
          st_nxt = ISP_H_RELEASE;
        end
      end
      ISP_H_RELEASE: begin
        cs_nxt = 1'b0;
        oe_nxt = 1'b0;
        rdy_nxt = 1'b1;
        st_nxt = ISP_H_IDLE;
      end
      default: begin
        st_nxt = ISP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ISP_H_IDLE;
      cnt_r <= '0;
      cs_r <= 1'b0;
      sel_r <= 1'b0;
      rd_r <= 1'b0;
      we_r <= 2'b00;
      d_r <= `ISP_DATA_RST;
      oe_r <= 1'b0;
      rsp_r <= `ISP_DATA_RST;
      rv_r <= 1'b0;
      rdy_r <= 1'b1;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cs_r <= cs_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
      we_r <= we_nxt;
      d_r <= d_nxt;
      oe_r <= oe_nxt;
      rsp_r <= rsp_nxt;
      rv_r <= rv_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign bus.chip_select_n = !cs_r;
  assign bus.cmd_data_select = sel_r;
  assign bus.read_strobe_n = !rd_r;
  assign bus.write_strobe_upper_n = !we_r[1];
  assign bus.write_strobe_lower_n = !we_r[0];
  assign bus.host_data = d_r;
  assign bus.host_data_oe = oe_r;
  assign req_ready_o = rdy_r;
  assign rsp_valid_o = rv_r;
  assign rsp_data_o = rsp_r;
endmodule

// file: verification/isp_checker.sv
// pin assertions between host and device ends
module isp_checker (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic chip_select_n,
  input wire logic cmd_data_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_upper_n,
  input wire logic write_strobe_lower_n,
  input wire logic host_data_oe,
  input wire logic [15:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic wait_oe
);
  logic rd;
  logic wr;
  logic act;
  assign rd = !chip_select_n && !read_strobe_n;
  assign wr = !chip_select_n && !(write_strobe_upper_n && write_strobe_lower_n);
  assign act = rd || wr;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence stall_run;
    wait_oe [*3] ##1 !wait_oe;
  endsequence
  chk_wait_len: assert property ($rose(wait_oe) |-> stall_run)
    else $error("stall length wrong");
  chk_wait_cause: assert property ($rose(wait_oe) |-> $past(act))
    else $error("stall without strobe");
  chk_wait_release: assert property (wait_oe |-> act)
    else $error("stall after strobe release");
  chk_read_drive: assert property (rd && wait_oe |-> dev_data_oe)
    else $error("read lines undriven");
  chk_oe_cause: assert property (dev_data_oe |-> $past(rd))
    else $error("data driven outside read");
  chk_oe_drop: assert property (dev_data_oe && !rd |=> !dev_data_oe)
    else $error("data lines held too long");
  chk_no_fight: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
  chk_data_hold: assert property ($fell(wait_oe) && rd |=> !rd || $stable(dev_data))
    else $error("read data moved after stall");
  chk_strobe_min: assert property ($rose(act) |-> act [*5])
    else $error("strobe too short");
  chk_read_pure: assert property (rd |-> write_strobe_upper_n && write_strobe_lower_n)
    else $error("write strobe during read");
  chk_cmd_full: assert property (wr && !cmd_data_select |-> !write_strobe_upper_n
    && !write_strobe_lower_n && read_strobe_n)
    else $error("command not full word");
endmodule

// file: verification/test_indirect_80_split_strobe_host_port.sv
// self-checking bench joining host and device ends
module test_indirect_80_split_strobe_host_port import isp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_b_i, wait_mode, req_valid, req_ready, rsp_valid, busy, bsy;
  logic [1:0] req_op, req_lanes;
  logic [15:0] req_data, rsp_data, reg_addr, last_wdata, rdv, a, d, e;
  logic [15:0] exp_mem [256];
  logic [15:0] addrs [8];
  int fails = 0, checked = 0, cyc = 0, m, i, k;
  isp_bus_if bus_if ();
  isp_host isp_host_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(1'h1),
    .wait_mode_i(wait_mode), .req_valid_i(req_valid), .req_op_i(req_op),
    .req_lanes_i(req_lanes), .req_data_i(req_data), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .bus(bus_if));
  isp_device isp_device_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(1'h1),
    .wait_mode_i(wait_mode), .bus(bus_if), .reg_addr_o(reg_addr),
    .last_wdata_o(last_wdata), .busy_o(busy));
  isp_checker isp_checker_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .chip_select_n(bus_if.chip_select_n), .cmd_data_select(bus_if.cmd_data_select),
    .read_strobe_n(bus_if.read_strobe_n), .write_strobe_upper_n(bus_if.write_strobe_upper_n),
    .write_strobe_lower_n(bus_if.write_strobe_lower_n), .host_data_oe(bus_if.host_data_oe),
    .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe), .wait_oe(bus_if.wait_oe));
  function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] ln);
    return {ln[1] ? n[15:8] : o[15:8], ln[0] ? n[7:0] : o[7:0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] ev, sv);
    checked++;
    if (sv !== ev) begin
      $display("unexpected %s expected %h seen %h", nm, ev, sv);
      fails++;
    end
  endtask
  task automatic xfer(input logic [1:0] op, ln, input logic [15:0] dv);
    int n;
    rdv = 16'hXXXX;
    bsy = 1'h0;
    req_op <= op;
    req_lanes <= ln;
    req_data <= dv;
    req_valid <= 1'h1;
    do @(posedge clock_i); while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    @(posedge clock_i);
    for (n = 0; n < 40 && req_ready !== 1'h1; n++) begin
      if (rsp_valid === 1'h1) rdv = rsp_data;
      if (busy === 1'h1) bsy = 1'h1;
      @(posedge clock_i);
    end
    if (rsp_valid === 1'h1) rdv = rsp_data;
    if (n == 40) begin
      $display("unexpected xfer_done expected 1 seen 0");
      fails++;
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clock_i = 1'h0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    void'($urandom(4319));
    rst_b_i = 1'h0;
    wait_mode = 1'h1;
    req_valid = 1'h0;
    req_op = 2'h0;
    req_lanes = 2'h0;
    req_data = 16'h0000;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'h1;
    for (m = 0; m < 2; m++) begin
      wait_mode <= (m == 0);
      for (i = 0; i < 4; i++) begin
        a = (i == 0) ? 16'hFFFF : ((i == 1) ? 16'h0001 : 16'($urandom));
        addrs[i] = a;
        xfer(ISP_OP_CMD, 2'h3, a);
        chk("reg_addr", {a[15:1], 1'h0}, reg_addr);
        for (k = 3; k > 0; k--) begin
          d = 16'($urandom);
          e = merge((k == 3) ? 16'h0000 : exp_mem[a[8:1]], d, 2'(k));
          exp_mem[a[8:1]] = e;
          xfer(ISP_OP_WR, 2'(k), d);
          if (k == 3) chk("last_wdata", d, last_wdata);
          xfer(ISP_OP_RD, 2'h0, 16'h0000);
          chk("read_word", e, rdv);
          chk("busy_seen", 16'h0001, {15'h0000, bsy});
          chk("busy_idle", 16'h0000, {15'h0000, busy});
        end
        chk("reg_addr_hold", {a[15:1], 1'h0}, reg_addr);
      end
      for (i = 0; i < 4; i++) begin
        xfer(ISP_OP_CMD, 2'h3, addrs[i]);
        xfer(ISP_OP_RD, 2'h0, 16'h0000);
        chk("reread_word", exp_mem[addrs[i][8:1]], rdv);
      end
    end
    close_out();
  end
endmodule
